/* File: design/wdit_pkg.sv */
// Constants for the watchdog interval timer: addresses, keys, reset values,
// field positions and pulse lengths.
// Assumes a 16-bit internal address with byte reads and word writes.
package wdit_pkg;
    // Addresses of the internal register bus.
    localparam logic [15:0] ADDR_CTRL_WR  = 16'hFFBC;
    localparam logic [15:0] ADDR_CTRL_RD  = 16'hFFBC;
    localparam logic [15:0] ADDR_CNT_RD   = 16'hFFBD;
    localparam logic [15:0] ADDR_RST_WR   = 16'hFFBE;
    localparam logic [15:0] ADDR_RST_RD   = 16'hFFBF;
    // Upper-byte keys of a word write.
    localparam logic [7:0]  KEY_COUNTER   = 8'h5A;
    localparam logic [7:0]  KEY_CONTROL   = 8'hA5;
    localparam logic [7:0]  CLEAR_DATA    = 8'h00;
    // Reset values.
    localparam logic [7:0]  CTRL_RESET    = 8'h18;
    localparam logic [7:0]  RST_RESET     = 8'h1F;
    localparam logic [7:0]  CNT_RESET     = 8'h00;
    localparam logic [7:0]  CNT_TOP       = 8'hFF;
    // Field positions.
    localparam int          FLAG_BIT      = 7;
    localparam int          MODE_BIT      = 6;
    localparam int          RUN_BIT       = 5;
    localparam int          OVERFLOW_RESET_ENABLE_BIT      = 6;
    localparam int          RESET_TYPE_SELECT_BIT      = 5;
    localparam logic [1:0]  CTRL_ONES     = 2'h3;
    localparam logic [4:0]  RST_ONES      = 5'h1F;
    // Pulse lengths in clock states.
    localparam logic [7:0]  PULSE_RESET   = 8'd132;
    localparam logic [7:0]  PULSE_NORESET = 8'd130;
    localparam logic [9:0]  CHIP_RST_LEN  = 10'd518;
endpackage

/* File: design/wdit_prescaler.sv */
// Count-clock prescaler: one-cycle tick at a selectable divisor of clk_i.
// Assumes the select is stable while running; the count is cleared when halted.
`timescale 1ns/10ps
module wdit_prescaler #(
    parameter int WIDTH = 17
) (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       run_i,
    input  wire logic [2:0] clock_divider_select_i,
    output logic            tick_o
);
    logic [WIDTH-1:0] div_count;

    // Number of low bits that must be all ones for each divisor.
    function automatic logic [WIDTH-1:0] div_mask(input logic [2:0] sel);
        logic [4:0] bits;
        bits = 5'd1;
        case (sel)
            3'h0: bits = 5'd1;
            3'h1: bits = 5'd6;
            3'h2: bits = 5'd7;
            3'h3: bits = 5'd9;
            3'h4: bits = 5'd11;
            3'h5: bits = 5'd13;
            3'h6: bits = 5'd15;
            default: bits = 5'd17;
        endcase
        div_mask = WIDTH'((18'h1 << bits) - 18'h1);
    endfunction

    // Free count while running; restarts from zero on every start.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            div_count <= '0;
        end else if (!run_i) begin
            div_count <= '0;
        end else begin
            div_count <= div_count + 1'b1;
        end
    end

    // Tick when the selected low bits are all ones.
    assign tick_o = run_i && ((div_count & div_mask(clock_divider_select_i))
                              == div_mask(clock_divider_select_i));
endmodule

/* File: design/wdit_top.sv */
// Watchdog interval timer: 8-bit counter, control and reset registers,
// overflow pulse, chip-internal reset request and interval interrupt.
// Assumes the CPU issues single-cycle byte reads and word or byte writes;
// rst_i is the external reset pin, already in the clk_i domain.
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// [R1] Reset register loads 1F on pin reset, keeps value on overflow reset.
// [R2] Watchdog flag sets on FF to 00 wrap in watchdog mode only.
// [R3] Watchdog flag clears only after a read with flag set, then clear write.
// [R4] Watchdog overflow resets counter and control register; chip reset only if enabled.
// [R5] Reset type bit chooses power-on (0) or manual (1) reset.
// [R6] Reset register bits 4 to 0 always read as one.
// [R7] Counter and control register take only word writes.
// [R8] Key 5A writes counter, key A5 writes control register.
// [R9] A5 with 00 at reset address clears flag, keeps enable and type.
// [R10] Key 5A at reset address loads enable and type, keeps flag.
// [R11] Byte reads: control at BC, counter at BD, reset register at BF.
// [R12] Overflow output low 132 states with reset enable, else 130.
// [R13] Chip reset starts with overflow output, lasts 518 states.
// [R14] Pin reset wins over overflow reset and leaves flag cleared.
// [R15] Interval overflow sets interval flag and requests interrupt together.
// [R16] Interval interrupt follows the interval flag.
// [R17] Counter write beats a coincident count tick.
// [R18] Software halts counting before changing the divider select.
// [R19] Software halts counting before switching modes.
// [R20] While output is low, writes ignored and flag reads not recognised.
// [R21] Software rewrites the counter before it overflows.
// [R22] Watchdog mode: mode and run set; interval: mode clear, run set.
// [R23] Count ticks come from one of eight clock divisors.
// [R24] Run bit clear holds counter at zero.
// [R25] Control register resets to 18, bits 4 and 3 read as one.
// [R26] Interval flag clears after read with flag set, then write of 0.
// [R27] Word writes with an unknown key change nothing.
module wdit_top (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [15:0] bus_addr_i,
    input  wire logic        bus_rd_i,
    input  wire logic        bus_wr_i,
    input  wire logic        bus_word_i,
    input  wire logic [15:0] bus_wdata_i,
    output logic      [7:0]  bus_rdata_o,
    output logic             overflow_output_n_o,
    output logic             chip_reset_o,
    output logic             reset_type_o,
    output logic             interval_interrupt_o
);
    logic [7:0] watch_counter;
    logic       interval_overflow_flag;
    logic       timer_mode_select;
    logic       count_run;
    logic [2:0] clock_divider_select;
    logic       watchdog_overflow_flag;
    logic       overflow_reset_enable;
    logic       reset_type_select;
    logic       itv_armed;
    logic       wdg_armed;
    logic [7:0] pulse_count;
    logic [9:0] chip_count;
    logic       tick;
    logic       busy;
    logic       word_wr;
    logic       cnt_wr;
    logic       ctrl_wr;
    logic       rst_cfg_wr;
    logic       rst_clr_wr;
    logic       overflow;
    logic       wdg_ovf;
    logic       itv_ovf;
    logic [7:0] ctrl_value;
    logic [7:0] rst_value;

    ////////////////////////////////////////////////////////////////////////////
    // Count tick source.
    wdit_prescaler #(
        .WIDTH (17)
    ) u_prescaler (
        .clk_i                  (clk_i),
        .rst_i                  (rst_i),
        .run_i                  (count_run),
        .clock_divider_select_i (clock_divider_select),
        .tick_o                 (tick)
    );                                                           // [R23]

    ////////////////////////////////////////////////////////////////////////////
    // Write decode. Byte writes and writes during the low output never match,
    // which leaves a crashing program only keyed word writes to reach these registers.
    assign busy       = (pulse_count != 8'h00);
    assign word_wr    = bus_wr_i && bus_word_i && !busy;         // [R7] [R20]
    assign cnt_wr     = word_wr && (bus_addr_i == wdit_pkg::ADDR_CTRL_WR)
                        && (bus_wdata_i[15:8] == wdit_pkg::KEY_COUNTER); // [R8]
    assign ctrl_wr    = word_wr && (bus_addr_i == wdit_pkg::ADDR_CTRL_WR)
                        && (bus_wdata_i[15:8] == wdit_pkg::KEY_CONTROL); // [R8]
    assign rst_cfg_wr = word_wr && (bus_addr_i == wdit_pkg::ADDR_RST_WR)
                        && (bus_wdata_i[15:8] == wdit_pkg::KEY_COUNTER); // [R10]
    assign rst_clr_wr = word_wr && (bus_addr_i == wdit_pkg::ADDR_RST_WR)
                        && (bus_wdata_i[15:8] == wdit_pkg::KEY_CONTROL)
                        && (bus_wdata_i[7:0] == wdit_pkg::CLEAR_DATA);   // [R9]

    // Overflow: a tick at FF, unless a counter write takes that cycle.
    assign overflow = count_run && tick && !cnt_wr
                      && (watch_counter == wdit_pkg::CNT_TOP);   // [R17]
    assign wdg_ovf  = overflow && timer_mode_select;             // [R2]
    assign itv_ovf  = overflow && !timer_mode_select;            // [R15]

    ////////////////////////////////////////////////////////////////////////////
    // Counter. A watchdog overflow resets it whether or not the chip resets.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            watch_counter <= wdit_pkg::CNT_RESET;
        end else if (wdg_ovf || !count_run) begin
            watch_counter <= wdit_pkg::CNT_RESET;                // [R4] [R24]
        end else if (cnt_wr) begin
            watch_counter <= bus_wdata_i[7:0];                   // [R8] [R17]
        end else if (tick) begin
            watch_counter <= watch_counter + 8'h01;
        end
    end

    // Control fields; an unknown key leaves them alone.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            timer_mode_select    <= wdit_pkg::CTRL_RESET[wdit_pkg::MODE_BIT];
            count_run            <= wdit_pkg::CTRL_RESET[wdit_pkg::RUN_BIT];
            clock_divider_select <= wdit_pkg::CTRL_RESET[2:0];   // [R25]
        end else if (wdg_ovf) begin
            timer_mode_select    <= wdit_pkg::CTRL_RESET[wdit_pkg::MODE_BIT];
            count_run            <= wdit_pkg::CTRL_RESET[wdit_pkg::RUN_BIT];
            clock_divider_select <= wdit_pkg::CTRL_RESET[2:0];   // [R4]
        end else if (ctrl_wr) begin
            timer_mode_select    <= bus_wdata_i[wdit_pkg::MODE_BIT];
            count_run            <= bus_wdata_i[wdit_pkg::RUN_BIT];
            clock_divider_select <= bus_wdata_i[2:0];            // [R27]
        end
    end

    // Interval flag: set wins over the clearing write in the same cycle.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            interval_overflow_flag <= 1'b0;
        end else if (itv_ovf) begin
            interval_overflow_flag <= 1'b1;                      // [R15]
        end else if (wdg_ovf) begin
            interval_overflow_flag <= 1'b0;                      // [R4]
        end else if (ctrl_wr && itv_armed
                     && !bus_wdata_i[wdit_pkg::FLAG_BIT]) begin
            interval_overflow_flag <= 1'b0;                      // [R26]
        end
    end

    // Interval clear is armed by reading the control register with flag set.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            itv_armed <= 1'b0;
        end else if (ctrl_wr || wdg_ovf) begin
            itv_armed <= 1'b0;
        end else if (bus_rd_i && interval_overflow_flag
                     && bus_addr_i == wdit_pkg::ADDR_CTRL_RD) begin
            itv_armed <= 1'b1;                                   // [R26]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reset register: only the pin reset reaches it, never the overflow.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            overflow_reset_enable <= wdit_pkg::RST_RESET[wdit_pkg::OVERFLOW_RESET_ENABLE_BIT];
            reset_type_select     <= wdit_pkg::RST_RESET[wdit_pkg::RESET_TYPE_SELECT_BIT];
        end else if (rst_cfg_wr) begin
            overflow_reset_enable <= bus_wdata_i[wdit_pkg::OVERFLOW_RESET_ENABLE_BIT]; // [R10]
            reset_type_select     <= bus_wdata_i[wdit_pkg::RESET_TYPE_SELECT_BIT]; // [R10]
        end
    end

    // Watchdog flag; a coincident pin reset wins because it is asynchronous.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            watchdog_overflow_flag <= 1'b0;                      // [R1] [R14]
        end else if (wdg_ovf) begin
            watchdog_overflow_flag <= 1'b1;                      // [R2]
        end else if (rst_clr_wr && wdg_armed) begin
            watchdog_overflow_flag <= 1'b0;                      // [R3] [R9]
        end
    end

    // Flag reads during the low output are not recognised for arming.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wdg_armed <= 1'b0;
        end else if (rst_clr_wr) begin
            wdg_armed <= 1'b0;
        end else if (bus_rd_i && watchdog_overflow_flag && !busy
                     && bus_addr_i == wdit_pkg::ADDR_RST_RD) begin
            wdg_armed <= 1'b1;                                   // [R3] [R20]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Overflow output pulse; its length depends on the reset enable.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pulse_count <= 8'h00;
        end else if (wdg_ovf) begin
            pulse_count <= overflow_reset_enable ? wdit_pkg::PULSE_RESET
                                                 : wdit_pkg::PULSE_NORESET;
        end else if (busy) begin
            pulse_count <= pulse_count - 8'h01;                  // [R12]
        end
    end

    // Chip reset request, started in the same cycle as the output pulse.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            chip_count   <= 10'h000;
            reset_type_o <= 1'b0;
        end else if (wdg_ovf && overflow_reset_enable) begin
            chip_count   <= wdit_pkg::CHIP_RST_LEN;              // [R13]
            reset_type_o <= reset_type_select;                   // [R5]
        end else if (chip_count != 10'h000) begin
            chip_count   <= chip_count - 10'h001;
        end
    end

    assign overflow_output_n_o  = !busy;                         // [R12]
    assign chip_reset_o         = (chip_count != 10'h000);       // [R4] [R13]
    assign interval_interrupt_o = interval_overflow_flag;        // [R16]

    ////////////////////////////////////////////////////////////////////////////
    // Read path: registered byte read, unmapped addresses read as zero.
    assign ctrl_value = {interval_overflow_flag, timer_mode_select, count_run,
                         wdit_pkg::CTRL_ONES, clock_divider_select}; // [R25]
    assign rst_value  = {watchdog_overflow_flag, overflow_reset_enable,
                         reset_type_select, wdit_pkg::RST_ONES}; // [R6]

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            bus_rdata_o <= 8'h00;
        end else if (bus_rd_i) begin
            case (bus_addr_i)
                wdit_pkg::ADDR_CTRL_RD: bus_rdata_o <= ctrl_value;    // [R11]
                wdit_pkg::ADDR_CNT_RD:  bus_rdata_o <= watch_counter; // [R11]
                wdit_pkg::ADDR_RST_RD:  bus_rdata_o <= rst_value;     // [R11]
                default:                bus_rdata_o <= 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks. The pulse length is counted from the overflow, the reset length from the rise of chip_reset_o.
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_low_132;
        ##132 !overflow_output_n_o ##1 overflow_output_n_o;
    endsequence
    sequence s_low_130;
        ##130 !overflow_output_n_o ##1 overflow_output_n_o;
    endsequence

    property p_pulse_overflow_reset_enable;
        wdg_ovf && overflow_reset_enable |-> s_low_132;
    endproperty
    a_pulse_overflow_reset_enable: assert property (p_pulse_overflow_reset_enable)                 // [R12]
        else $error("overflow output not low for 132 states");

    property p_pulse_norste;
        wdg_ovf && !overflow_reset_enable |-> s_low_130;
    endproperty
    a_pulse_norste: assert property (p_pulse_norste)             // [R12]
        else $error("overflow output not low for 130 states");

    property p_chip_reset;
        wdg_ovf && overflow_reset_enable |=> chip_reset_o
            && reset_type_o == $past(reset_type_select);
    endproperty
    a_chip_reset: assert property (p_chip_reset)                 // [R13]
        else $error("chip reset start or type wrong");

    // Helper count of the cycles the chip reset stands, too long to unroll.
    logic [9:0] chip_high_len;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            chip_high_len <= 10'h000;
        end else begin
            chip_high_len <= chip_reset_o ? chip_high_len + 10'h001 : 10'h000;
        end
    end

    property p_chip_len;
        $fell(chip_reset_o) |-> chip_high_len == wdit_pkg::CHIP_RST_LEN;
    endproperty
    a_chip_len: assert property (p_chip_len)                     // [R13]
        else $error("chip reset length wrong");

    property p_wdg_set;
        $rose(watchdog_overflow_flag) |-> $past(wdg_ovf);
    endproperty
    a_wdg_set: assert property (p_wdg_set)                       // [R2]
        else $error("watchdog flag set without watchdog overflow");

    property p_itv_irq;
        itv_ovf |=> interval_interrupt_o && !$rose(watchdog_overflow_flag)[*1];
    endproperty
    a_itv_irq: assert property (p_itv_irq)                       // [R15]
        else $error("interval overflow did not raise interrupt");

    property p_busy_nowrite;
        !overflow_output_n_o && bus_wr_i |=>
            $stable(overflow_reset_enable) && $stable(reset_type_select);
    endproperty
    a_busy_nowrite: assert property (p_busy_nowrite)             // [R20]
        else $error("register written while output low");

    property p_byte_wr;
        bus_wr_i && !bus_word_i && !wdg_ovf |=>
            $stable(clock_divider_select) && $stable(count_run);
    endproperty
    a_byte_wr: assert property (p_byte_wr)                       // [R7]
        else $error("byte write changed control register");

    property p_cnt_write;
        cnt_wr && count_run && !wdg_ovf |=>
            watch_counter == $past(bus_wdata_i[7:0]);
    endproperty
    a_cnt_write: assert property (p_cnt_write)                   // [R17]
        else $error("counter write lost to increment");

    property p_halt;
        !count_run |=> watch_counter == 8'h00;
    endproperty
    a_halt: assert property (p_halt)                             // [R24]
        else $error("counter not held at zero while halted");

    property p_rst_read;
        bus_rd_i && bus_addr_i == wdit_pkg::ADDR_RST_RD |=>
            bus_rdata_o[4:0] == 5'h1F;
    endproperty
    a_rst_read: assert property (p_rst_read)                     // [R6]
        else $error("reserved reset bits not read as one");
endmodule

/* File: tb/wdit_cpu_model.sv */
// CPU side of the watchdog timer register bus: byte reads, byte or word
// writes, one request at a time.
// Assumes the timer answers reads one cycle after the read edge.
`timescale 1ns/10ps
module wdit_cpu_model (
    input  wire logic        clk_i,
    input  wire logic [7:0]  bus_rdata_i,
    output logic      [15:0] bus_addr_o,
    output logic             bus_rd_o,
    output logic             bus_wr_o,
    output logic             bus_word_o,
    output logic      [15:0] bus_wdata_o
);
    ////////////////////////////////////////////////////////////////////////
    // Idle bus levels at time zero.
    initial begin
        bus_addr_o = 16'h0000;
        bus_rd_o = 1'b0;
        bus_wr_o = 1'b0;
        bus_word_o = 1'b0;
        bus_wdata_o = 16'h0000;
    end

    // One write; released lines show inverted data, never the old value.
    task automatic wr(input logic [15:0] addr, input logic [15:0] data,
                      input logic word);
        @(posedge clk_i);
        bus_addr_o <= addr;
        bus_wdata_o <= data;
        bus_word_o <= word;
        bus_wr_o <= 1'b1;
        @(posedge clk_i);
        bus_wr_o <= 1'b0;
        bus_addr_o <= ~addr;
        bus_wdata_o <= ~data;
    endtask

    // One byte read; the data stands from the cycle after the read edge.
    task automatic rd(input logic [15:0] addr, output logic [7:0] data);
        @(posedge clk_i);
        bus_addr_o <= addr;
        bus_rd_o <= 1'b1;
        @(posedge clk_i);
        bus_rd_o <= 1'b0;
        bus_addr_o <= ~addr;
        @(posedge clk_i);
        data = bus_rdata_i;
    endtask
endmodule

/* File: tb/watchdog_interval_timer_bench.sv */
// Self-checking bench for the watchdog interval timer.
// Assumes the CPU model drives the bus and the timer runs at 100 MHz.
`timescale 1ns/10ps
module watchdog_interval_timer_bench;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [15:0] bus_addr;
    logic        bus_rd;
    logic        bus_wr;
    logic        bus_word;
    logic [15:0] bus_wdata;
    logic [7:0]  bus_rdata;
    logic        ovf_n;
    logic        chip_rst;
    logic        rst_type;
    logic        irq;
    logic        type_seen = 1'b0;
    logic [7:0]  q;
    int          bad_count = 0;
    int          checked = 0;
    int          cycles = 0;
    int          low_cycles = 0;
    int          rst_cycles = 0;
    int          n0;
    int          r0;

    always #5 clk_i = ~clk_i;

    ////////////////////////////////////////////////////////////////////////
    wdit_top wdit_top_i (
        .clk_i(clk_i), .rst_i(rst_i), .bus_addr_i(bus_addr),
        .bus_rd_i(bus_rd), .bus_wr_i(bus_wr), .bus_word_i(bus_word),
        .bus_wdata_i(bus_wdata), .bus_rdata_o(bus_rdata),
        .overflow_output_n_o(ovf_n), .chip_reset_o(chip_rst),
        .reset_type_o(rst_type), .interval_interrupt_o(irq));

    wdit_cpu_model wdit_cpu_model_i (
        .clk_i(clk_i), .bus_rdata_i(bus_rdata), .bus_addr_o(bus_addr),
        .bus_rd_o(bus_rd), .bus_wr_o(bus_wr), .bus_word_o(bus_word),
        .bus_wdata_o(bus_wdata));

    ////////////////////////////////////////////////////////////////////////
    // Pulse lengths are summed here so no scenario has to poll every cycle.
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (ovf_n === 1'b0) begin
            low_cycles <= low_cycles + 1;
        end
        if (chip_rst === 1'b1) begin
            rst_cycles <= rst_cycles + 1;
            type_seen <= rst_type;
        end
        if (cycles == 6000) begin
            bad_count++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        if (bad_count == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        wdit_cpu_model_i.wr(a, d, 1'b1);
    endtask

    task automatic rd_chk(input string what, input logic [15:0] a,
                          input logic [7:0] e);
        wdit_cpu_model_i.rd(a, q);
        check(what, {8'h00, q}, {8'h00, e});
    endtask

    // Bounded wait for the overflow pulse; a miss is a mismatch.
    task automatic wait_low();
        for (int i = 0; i < 100 && ovf_n !== 1'b0; i++) begin
            @(posedge clk_i);
        end
        check("overflow low", {15'h0000, ovf_n}, 16'h0000);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence; each block below is one scenario.
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        rd_chk("control", 16'hFFBC, 8'h18);
        rd_chk("counter", 16'hFFBD, 8'h00);
        rd_chk("reset reg", 16'hFFBF, 8'h1F);
        rd_chk("unmapped", 16'hFF00, 8'h00);
        // Refused writes leave every register as it was.
        wdit_cpu_model_i.wr(16'hFFBC, 16'hA520, 1'b0);
        rd_chk("byte write", 16'hFFBC, 8'h18);
        wr(16'hFFBC, 16'h3C20);
        rd_chk("bad key", 16'hFFBC, 8'h18);
        wr(16'hFFBE, 16'h3C60);
        rd_chk("bad key rst", 16'hFFBF, 8'h1F);
        // Slowest divisor keeps the counter still while it is read back.
        wr(16'hFFBC, 16'hA527);
        wr(16'hFFBC, 16'h5A37);
        rd_chk("counter write", 16'hFFBD, 8'h37);
        wr(16'hFFBC, 16'hA507);
        rd_chk("halted counter", 16'hFFBD, 8'h00);
        // Divide by 64: two ticks have landed by the read, the third not yet.
        wr(16'hFFBC, 16'hA521);
        repeat (150) @(posedge clk_i);
        rd_chk("divide by 64", 16'hFFBD, 8'h02);
        wr(16'hFFBC, 16'hA501);
        wr(16'hFFBC, 16'hA520);
        wr(16'hFFBC, 16'h5AFE);
        for (int i = 0; i < 100 && irq !== 1'b1; i++) begin
            @(posedge clk_i);
        end
        check("interrupt", {15'h0000, irq}, 16'h0001);
        wr(16'hFFBC, 16'hA520);
        // The flag updates on the write edge, so look once it has settled.
        @(negedge clk_i);
        check("clear unarmed", {15'h0000, irq}, 16'h0001);
        rd_chk("interval flag", 16'hFFBC, 8'hB8);
        wr(16'hFFBC, 16'hA520);
        @(negedge clk_i);
        check("clear armed", {15'h0000, irq}, 16'h0000);
        rd_chk("no watchdog flag", 16'hFFBF, 8'h1F);
        wr(16'hFFBC, 16'hA500);
        // Watchdog overflow with chip reset, manual type.
        wr(16'hFFBE, 16'h5A60);
        rd_chk("enable type", 16'hFFBF, 8'h7F);
        n0 = low_cycles;
        r0 = rst_cycles;
        wr(16'hFFBC, 16'hA560);
        wr(16'hFFBC, 16'h5AFE);
        wait_low();
        wr(16'hFFBE, 16'h5A00);
        wdit_cpu_model_i.rd(16'hFFBF, q);
        repeat (600) @(posedge clk_i);
        check("low length", 16'(low_cycles - n0), 16'd132);
        check("reset length", 16'(rst_cycles - r0), 16'd518);
        check("reset type", {15'h0000, type_seen}, 16'h0001);
        wr(16'hFFBE, 16'hA500);
        rd_chk("flag kept", 16'hFFBF, 8'hFF);
        rd_chk("control reset", 16'hFFBC, 8'h18);
        wr(16'hFFBE, 16'hA500);
        rd_chk("flag cleared", 16'hFFBF, 8'h7F);
        // Watchdog overflow without chip reset.
        wr(16'hFFBE, 16'h5A00);
        n0 = low_cycles;
        r0 = rst_cycles;
        wr(16'hFFBC, 16'hA560);
        wr(16'hFFBC, 16'h5AFE);
        wait_low();
        repeat (600) @(posedge clk_i);
        check("low short", 16'(low_cycles - n0), 16'd130);
        check("no chip reset", 16'(rst_cycles - r0), 16'd0);
        rd_chk("flag only", 16'hFFBF, 8'h9F);
        // Watchdog overflow with chip reset, power-on type.
        wr(16'hFFBE, 16'h5A40);
        r0 = rst_cycles;
        wr(16'hFFBC, 16'hA560);
        wr(16'hFFBC, 16'h5AFE);
        wait_low();
        repeat (600) @(posedge clk_i);
        check("reset length 2", 16'(rst_cycles - r0), 16'd518);
        check("power-on type", {15'h0000, type_seen}, 16'h0000);
        // The pin reset reloads the reset register and clears the flag.
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd_chk("pin reset", 16'hFFBF, 8'h1F);
        report_and_stop();
    end
endmodule
